// >>> hw/dsc_pkg.sv
// package for the debug state capture register group
// assumes a single 25 MHz core clock domain
package dsc_pkg;

    // ****************************************
    // register indices and byte addresses
    // ****************************************
    localparam logic [7:0] IDX_SAVED_PC     = 8'h11;
    localparam logic [7:0] IDX_SAVED_SP     = 8'h12;
    localparam logic [7:0] IDX_CORE_SEL     = 8'h13;
    localparam logic [7:0] IDX_REG_SEL      = 8'h14;
    localparam logic [7:0] IDX_TRIG_CAUSE   = 8'h15;
    localparam int         ADDR_W           = 10;
    localparam logic [9:0] ADDR_SAVED_PC    = {IDX_SAVED_PC, 2'h0};
    localparam logic [9:0] ADDR_SAVED_SP    = {IDX_SAVED_SP, 2'h0};
    localparam logic [9:0] ADDR_CORE_SEL    = {IDX_CORE_SEL, 2'h0};
    localparam logic [9:0] ADDR_REG_SEL     = {IDX_REG_SEL, 2'h0};
    localparam logic [9:0] ADDR_TRIG_CAUSE  = {IDX_TRIG_CAUSE, 2'h0};

    // ****************************************
    // field positions and widths
    // ****************************************
    localparam int CORE_SEL_W   = 8;
    localparam int REG_SEL_W    = 5;
    localparam int CAUSE_LSB    = 0;
    localparam int CAUSE_W      = 3;
    localparam int THREAD_LSB   = 8;
    localparam int THREAD_W     = 8;
    localparam int BP_LSB       = 16;
    localparam int BP_W         = 2;
    localparam int NUM_BP       = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ****************************************
    // debug interrupt causes
    // ****************************************
    typedef enum logic [2:0] {
        DSC_CAUSE_NONE  = 3'h0,
        DSC_CAUSE_HOST  = 3'h1,
        DSC_CAUSE_CALL  = 3'h2,
        DSC_CAUSE_IBRK  = 3'h3,
        DSC_CAUSE_WATCH = 3'h4
    } dsc_cause_t;

endpackage : dsc_pkg

// >>> hw/dsc_regs.sv
// debug state capture registers: saved pc/sp, register-fetch operands, trigger cause
// assumes core-side request signals on clk_sys_i; register port of the same clock
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module dsc_regs (
    input  wire logic                      clk_sys_i,
    input  wire logic                      rstn_i,
    input  wire logic                      clk_en_i,
    input  wire logic [dsc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [31:0]               wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [31:0]               rdata_o,
    input  wire logic                      debug_mode_i,
    input  wire logic                      dbg_host_req_i,
    input  wire logic                      dbg_call_i,
    input  wire logic [dsc_pkg::NUM_BP-1:0] ibrk_hit_i,
    input  wire logic [dsc_pkg::NUM_BP-1:0] watch_hit_i,
    input  wire logic [7:0]                thread_i,
    input  wire logic [31:0]               pc_i,
    input  wire logic [31:0]               sp_i,
    output logic [dsc_pkg::CORE_SEL_W-1:0] fetch_core_id_o,
    output logic [dsc_pkg::REG_SEL_W-1:0]  fetch_register_index_o
);

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [1:0] lowest_hit(input logic [3:0] hits);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (hits[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction : lowest_hit

    // ****************************************
    // state
    // ****************************************
    logic [31:0]                    pc_r,     pc_nxt;
    logic [31:0]                    sp_r,     sp_nxt;
    logic [dsc_pkg::CORE_SEL_W-1:0] core_r,   core_nxt;
    logic [dsc_pkg::REG_SEL_W-1:0]  rsel_r,   rsel_nxt;
    logic [2:0]                     cause_r,  cause_nxt;
    logic [7:0]                     thread_r, thread_nxt;
    logic [1:0]                     bp_r,     bp_nxt;
    logic [31:0]                    rdata_r,  rdata_nxt;
    logic                           entry;
    logic                           wr_ok;

    // debug entry on any trigger while not yet in debug mode
    assign entry = !debug_mode_i && (dbg_host_req_i || dbg_call_i
                   || (|ibrk_hit_i) || (|watch_hit_i));
    assign wr_ok = wr_i && debug_mode_i;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        pc_nxt     = pc_r;
        sp_nxt     = sp_r;
        core_nxt   = core_r;
        rsel_nxt   = rsel_r;
        cause_nxt  = cause_r;
        thread_nxt = thread_r;
        bp_nxt     = bp_r;
        if (entry) begin
            pc_nxt = pc_i;
            sp_nxt = sp_i;
            // priority host > call > ibrk > watch
            if (dbg_host_req_i) begin
                cause_nxt  = dsc_pkg::DSC_CAUSE_HOST;
                thread_nxt = 8'h00;
                bp_nxt     = 2'h0;
            end else if (dbg_call_i) begin
                cause_nxt  = dsc_pkg::DSC_CAUSE_CALL;
                thread_nxt = thread_i;
                bp_nxt     = 2'h0;
            end else if (|ibrk_hit_i) begin
                cause_nxt  = dsc_pkg::DSC_CAUSE_IBRK;
                thread_nxt = thread_i;
                bp_nxt     = lowest_hit(ibrk_hit_i);
            end else begin
                cause_nxt  = dsc_pkg::DSC_CAUSE_WATCH;
                thread_nxt = thread_i;
                bp_nxt     = lowest_hit(watch_hit_i);
            end
        end else if (wr_ok) begin
            if (addr_i == dsc_pkg::ADDR_SAVED_PC) begin
                pc_nxt = wdata_i;
            end else if (addr_i == dsc_pkg::ADDR_SAVED_SP) begin
                sp_nxt = wdata_i;
            end else if (addr_i == dsc_pkg::ADDR_CORE_SEL) begin
                core_nxt = wdata_i[dsc_pkg::CORE_SEL_W-1:0];
            end else if (addr_i == dsc_pkg::ADDR_REG_SEL) begin
                rsel_nxt = wdata_i[dsc_pkg::REG_SEL_W-1:0];
            end else if (addr_i == dsc_pkg::ADDR_TRIG_CAUSE) begin
                cause_nxt  = wdata_i[dsc_pkg::CAUSE_LSB +: dsc_pkg::CAUSE_W];
                thread_nxt = wdata_i[dsc_pkg::THREAD_LSB +: dsc_pkg::THREAD_W];
                bp_nxt     = wdata_i[dsc_pkg::BP_LSB +: dsc_pkg::BP_W];
            end
        end
    end

    // ****************************************
    // read mux, reserved bits zero
    // ****************************************
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (rd_i) begin
            if (addr_i == dsc_pkg::ADDR_SAVED_PC) begin
                rdata_nxt = pc_r;
            end else if (addr_i == dsc_pkg::ADDR_SAVED_SP) begin
                rdata_nxt = sp_r;
            end else if (addr_i == dsc_pkg::ADDR_CORE_SEL) begin
                rdata_nxt = {24'h00_0000, core_r};
            end else if (addr_i == dsc_pkg::ADDR_REG_SEL) begin
                rdata_nxt = {27'h000_0000, rsel_r};
            end else if (addr_i == dsc_pkg::ADDR_TRIG_CAUSE) begin
                rdata_nxt = {14'h0000, bp_r, thread_r, 5'h00, cause_r};
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_r     <= dsc_pkg::RST_WORD;
            sp_r     <= dsc_pkg::RST_WORD;
            core_r   <= '0;
            rsel_r   <= '0;
            cause_r  <= 3'h0;
            thread_r <= 8'h00;
            bp_r     <= 2'h0;
            rdata_r  <= dsc_pkg::RST_WORD;
        end else if (clk_en_i) begin
            pc_r     <= pc_nxt;
            sp_r     <= sp_nxt;
            core_r   <= core_nxt;
            rsel_r   <= rsel_nxt;
            cause_r  <= cause_nxt;
            thread_r <= thread_nxt;
            bp_r     <= bp_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign rdata_o                = rdata_r;
    assign fetch_core_id_o        = core_r;
    assign fetch_register_index_o = rsel_r;

    // ****************************************
    // checks
    // ****************************************
    a_pc_capture: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (entry && clk_en_i) |=> (pc_r == $past(pc_i)))
        else $error("saved pc not captured");
    a_sp_capture: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (entry && clk_en_i) |=> (sp_r == $past(sp_i)))
        else $error("saved sp not captured");
    a_core_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_i && clk_en_i && addr_i == dsc_pkg::ADDR_CORE_SEL) |=> (rdata_o[31:8] == 24'h00_0000))
        else $error("core select reserved bits nonzero");
    a_reg_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_i && clk_en_i && addr_i == dsc_pkg::ADDR_REG_SEL)
        |=> (rdata_o == {27'h0, $past(rsel_r)}))
        else $error("register select readback wrong");
    a_host_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (entry && clk_en_i && (dbg_host_req_i || dbg_call_i)) |=> (bp_r == 2'h0))
        else $error("bp index not zero for host or call");
    a_lowest_bp: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (entry && clk_en_i && !dbg_host_req_i && !dbg_call_i && ibrk_hit_i[0]) |=> (bp_r == 2'h0))
        else $error("lowest breakpoint not chosen");
    a_cause_code: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (entry && clk_en_i && dbg_host_req_i) |=> (cause_r == 3'h1 && thread_r == 8'h00))
        else $error("host cause or thread wrong");
    a_wr_block: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_i && clk_en_i && !debug_mode_i && !entry) |=> $stable(core_r) && $stable(rsel_r))
        else $error("write outside debug mode took effect");
    a_call_cause: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (entry && clk_en_i && !dbg_host_req_i && dbg_call_i)
        |=> (cause_r == 3'h2 && thread_r == $past(thread_i)))
        else $error("call cause or thread wrong");
    a_brk_cause: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (entry && clk_en_i && !dbg_host_req_i && !dbg_call_i && (|ibrk_hit_i))
        |=> (cause_r == 3'h3 && thread_r == $past(thread_i)))
        else $error("breakpoint cause or thread wrong");
    a_watch_cause: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (entry && clk_en_i && !dbg_host_req_i && !dbg_call_i && !(|ibrk_hit_i))
        |=> (cause_r == 3'h4 && thread_r == $past(thread_i)))
        else $error("watchpoint cause or thread wrong");
    a_bp_second: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (entry && clk_en_i && !dbg_host_req_i && !dbg_call_i && ibrk_hit_i[1:0] == 2'h2)
        |=> (bp_r == 2'h1))
        else $error("breakpoint index one not chosen");
    a_bp_third: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (entry && clk_en_i && !dbg_host_req_i && !dbg_call_i && !(|ibrk_hit_i)
         && watch_hit_i[2:0] == 3'h4) |=> (bp_r == 2'h2))
        else $error("watchpoint index two not chosen");
    a_cause_reserved: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_i && clk_en_i && addr_i == dsc_pkg::ADDR_TRIG_CAUSE)
        |=> (rdata_o[31:18] == 14'h0000 && rdata_o[7:3] == 5'h00))
        else $error("cause reserved bits nonzero");
    a_rdata_idle: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (!rd_i && clk_en_i) |=> (rdata_o == 32'h0000_0000))
        else $error("read data not zero without a read");
    a_en_freeze: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (!clk_en_i) |=> ($stable(pc_r) && $stable(sp_r) && $stable(rdata_o)))
        else $error("state moved while clock enable low");

endmodule : dsc_regs

`default_nettype wire

// >>> test/dsc_debugger.sv
// debugger model: bus master on the register port of the capture block
// assumes the block's clock and a slave that never stalls
`timescale 1ns/1ps
`default_nettype none

module dsc_debugger (
    input  wire logic        clk_sys_i,
    input  wire logic [31:0] rdata_i,
    output var  logic [9:0]  addr_o,
    output var  logic [31:0] wdata_o,
    output var  logic        wr_o,
    output var  logic        rd_o
);
    // ****************************************
    // bus cycles
    // ****************************************
    initial begin
        addr_o  = 10'h000;
        wdata_o = 32'h0;
        wr_o    = 1'h0;
        rd_o    = 1'h0;
    end

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'h1;
        @(posedge clk_sys_i);
        wr_o    <= 1'h0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask : wr

    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_o   <= 1'h1;
        @(posedge clk_sys_i);
        rd_o   <= 1'h0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : rd
endmodule : dsc_debugger
`default_nettype wire

// >>> test/test_dsc_regs.sv
// self-checking bench for the capture registers
// assumes dsc_debugger as bus master; core triggers driven here
`timescale 1ns/1ps
`default_nettype none

module test_dsc_regs;
    logic        clk_sys_i = 1'h0;
    logic        rstn_i    = 1'h0;
    logic [9:0]  addr;
    logic [31:0] wdata, rdata, pc = 32'h0, sp = 32'h0;
    logic        wr, rd, dmode = 1'h0, host = 1'h0, call = 1'h0, en = 1'h1;
    logic [3:0]  ibrk = 4'h0, watch = 4'h0;
    logic [7:0]  thr = 8'h0, core_id;
    logic [4:0]  reg_idx;
    int          failures = 0, n_checks = 0;
    logic [31:0] cause_exp [4] = '{32'h0000_0001, 32'h0000_5b02, 32'h0001_5c03, 32'h0002_5d04};
    logic [9:0]  stim [4] = '{10'h202, 10'h102, 10'h061, 10'h00c};

    always #20 clk_sys_i = ~clk_sys_i;

    dsc_debugger i_dbg (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    dsc_regs i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .clk_en_i(en), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .debug_mode_i(dmode),
        .dbg_host_req_i(host), .dbg_call_i(call), .ibrk_hit_i(ibrk), .watch_hit_i(watch),
        .thread_i(thr), .pc_i(pc), .sp_i(sp), .fetch_core_id_o(core_id),
        .fetch_register_index_o(reg_idx));

    // ****************************************
    // checks and stimulus
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rchk(input string n, input logic [9:0] a, input logic [31:0] e);
        logic [31:0] d;
        i_dbg.rd(a, d);
        chk(n, e, d);
    endtask : rchk

    task automatic summarize();
        if (failures == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize

    initial begin
        #200000;
        failures++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge clk_sys_i);
        rstn_i <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            rchk("reset", {dsc_pkg::IDX_SAVED_PC + 8'(i), 2'h0}, dsc_pkg::RST_WORD);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_i);
            {host, call, ibrk, watch} <= stim[i];
            dmode <= 1'h0;
            thr   <= 8'h5a + 8'(i);
            pc    <= 32'h1000_0000 + i;
            sp    <= 32'h2000_0000 + i;
            @(posedge clk_sys_i);
            {host, call, ibrk, watch} <= 10'h000;
            dmode <= 1'h1;
            pc    <= 32'h0;
            sp    <= 32'h0;
            rchk("pc", dsc_pkg::ADDR_SAVED_PC, 32'h1000_0000 + i);
            rchk("sp", dsc_pkg::ADDR_SAVED_SP, 32'h2000_0000 + i);
            rchk("cause", dsc_pkg::ADDR_TRIG_CAUSE, cause_exp[i]);
        end
        @(posedge clk_sys_i);
        ibrk <= 4'h1;
        rchk("ignored", dsc_pkg::ADDR_TRIG_CAUSE, cause_exp[3]);
        @(posedge clk_sys_i);
        ibrk <= 4'h0;
        i_dbg.wr(dsc_pkg::ADDR_CORE_SEL, 32'hffff_ffff);
        i_dbg.wr(dsc_pkg::ADDR_REG_SEL, 32'hffff_ffff);
        i_dbg.wr(dsc_pkg::ADDR_SAVED_PC, 32'hdead_beef);
        i_dbg.wr(dsc_pkg::ADDR_SAVED_SP, 32'h0bad_f00d);
        i_dbg.wr(dsc_pkg::ADDR_TRIG_CAUSE, 32'hffff_ffff);
        rchk("core", dsc_pkg::ADDR_CORE_SEL, 32'h0000_00ff);
        chk("core_out", 32'h0000_00ff, {24'h0, core_id});
        rchk("regsel", dsc_pkg::ADDR_REG_SEL, 32'h0000_001f);
        chk("reg_out", 32'h0000_001f, {27'h0, reg_idx});
        rchk("pc_wr", dsc_pkg::ADDR_SAVED_PC, 32'hdead_beef);
        rchk("sp_wr", dsc_pkg::ADDR_SAVED_SP, 32'h0bad_f00d);
        rchk("cause_wr", dsc_pkg::ADDR_TRIG_CAUSE, 32'h0003_ff07);
        // write while clock enable is low must not land
        @(posedge clk_sys_i);
        en <= 1'h0;
        i_dbg.wr(dsc_pkg::ADDR_SAVED_PC, 32'h1234_5678);
        @(posedge clk_sys_i);
        en <= 1'h1;
        rchk("pc_frozen", dsc_pkg::ADDR_SAVED_PC, 32'hdead_beef);
        @(posedge clk_sys_i);
        dmode <= 1'h0;
        i_dbg.wr(dsc_pkg::ADDR_SAVED_PC, 32'h1234_5678);
        i_dbg.wr(dsc_pkg::ADDR_CORE_SEL, 32'h0000_0012);
        rchk("pc_locked", dsc_pkg::ADDR_SAVED_PC, 32'hdead_beef);
        rchk("core_locked", dsc_pkg::ADDR_CORE_SEL, 32'h0000_00ff);
        // second reset in mid-run
        @(posedge clk_sys_i);
        rstn_i <= 1'h0;
        @(posedge clk_sys_i);
        rstn_i <= 1'h1;
        rchk("pc_reset", dsc_pkg::ADDR_SAVED_PC, dsc_pkg::RST_WORD);
        chk("core_reset", dsc_pkg::RST_WORD, {24'h0, core_id});
        rchk("unmapped", 10'h040, 32'h0);
        summarize();
    end
endmodule : test_dsc_regs
`default_nettype wire
